// ===== rtl/dma_pkg.sv
/*
  constants, field positions and types shared by the two-channel dma controller.
  assumes a 20-bit byte address space and a 16-bit internal data bus.
*/
package dma_pkg;
  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int ADDR_W = 20;     // byte address width
  localparam int DATA_W = 16;     // internal data bus width
  localparam int COUNT_W = 16;    // transfer counter width
  localparam int FIFO_DEPTH = 8;  // unit buffer depth
  localparam int PERIPH_N = 15;   // timers, uarts, a-d, usb request lines
  localparam int SEL_W = 5;       // request selector width

  // ----------------------------------------
  // address map limits
  // ----------------------------------------
  localparam logic [19:0] GUARD_LO = 20'h00020; // controller's own registers, low end
  localparam logic [19:0] GUARD_HI = 20'h0003f; // controller's own registers, high end
  localparam logic [19:0] SFR_TOP = 20'h003ff;  // end of register area
  localparam logic [19:0] STEP_BYTE = 20'h00001;
  localparam logic [19:0] STEP_WORD = 20'h00002;

  // ----------------------------------------
  // bus cycle coefficients j and k
  // ----------------------------------------
  localparam logic [1:0] WAIT_FAST = 2'h1; // no-wait internal memory
  localparam logic [1:0] WAIT_SLOW = 2'h2; // waited memory or register area

  // ----------------------------------------
  // configuration port selects
  // ----------------------------------------
  localparam logic [2:0] REG_SRC = 3'h0;
  localparam logic [2:0] REG_DST = 3'h1;
  localparam logic [2:0] REG_RELOAD = 3'h2;
  localparam logic [2:0] REG_COUNT = 3'h3;
  localparam logic [2:0] REG_CTRL = 3'h4;

  // ----------------------------------------
  // control word fields
  // ----------------------------------------
  localparam int CTL_EN = 0;       // channel enable
  localparam int CTL_REPEAT = 1;   // 1 = repeat mode
  localparam int CTL_UNIT8 = 2;    // unit_size_select, 1 = 8-bit
  localparam int CTL_SRC_FWD = 3;  // source forward
  localparam int CTL_DST_FWD = 4;  // destination forward
  localparam int CTL_SEL_LO = 5;   // request selector, 5 bits
  localparam int CTL_W = 10;
  localparam logic [4:0] SEL_EXT = 5'h0f; // falling edge of the channel's external line
  localparam logic [4:0] SEL_SW = 5'h10;  // software trigger

  typedef enum logic [2:0] {S_IDLE, S_RD, S_PUSH, S_POP, S_WR, S_DONE} engine_state_t;
endpackage

// ===== rtl/two_channel_dma_controller.sv
/*
  two-channel cycle-stealing dma engine with its unit buffer.
  assumes an arbiter answering bus_request with bus_grant, and a bus that
  returns read data in a strobe's last cycle, bytes in the low lane.
*/
`timescale 1ns/100ps

// ----------------------------------------
// unit buffer
// ----------------------------------------
module unit_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH); // depth must be a power of two
  logic [WIDTH-1:0] mem [DEPTH];      // storage, no reset needed
  logic [AW:0] wr_ptr;                // extra bit tells full from empty
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // pointer update
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // data store
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// ----------------------------------------
// controller top
// ----------------------------------------
module two_channel_dma_controller #(
  parameter int FIFO_DEPTH = dma_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic external_irq_line_zero,
  input wire logic external_irq_line_one,
  input wire logic [dma_pkg::PERIPH_N-1:0] periph_request,
  input wire logic [1:0] soft_trigger,
  input wire logic soft_wait_enable,
  input wire logic cfg_write,
  input wire logic cfg_channel,
  input wire logic [2:0] cfg_select,
  input wire logic [dma_pkg::ADDR_W-1:0] cfg_data,
  input wire logic view_channel,
  input wire logic [2:0] view_select,
  output logic [dma_pkg::ADDR_W-1:0] view_data,
  input wire logic bus_grant,
  input wire logic [dma_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_request,
  output logic bus_strobe,
  output logic bus_write,
  output logic bus_wide,
  output logic [dma_pkg::ADDR_W-1:0] bus_addr,
  output logic [dma_pkg::DATA_W-1:0] bus_wdata,
  output logic [1:0] channel_enabled,
  output logic [1:0] transfer_irq
);
  // ----------------------------------------
  // external line synchronisers
  // ----------------------------------------
  logic [1:0] ext_s1; // first stage, read only by ext_s2
  logic [1:0] ext_s2;
  logic [1:0] ext_s3; // previous level for edge detect
  wire [1:0] ext_pins = {external_irq_line_one, external_irq_line_zero};
  wire [1:0] ext_fall = ext_s3 & ~ext_s2;

  // idle-high reset avoids a false edge at release
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ext_s1 <= 2'h3;
      ext_s2 <= 2'h3;
      ext_s3 <= 2'h3;
    end
    else
    begin
      ext_s1 <= ext_pins;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // ----------------------------------------
  // engine to channel wiring
  // ----------------------------------------
  dma_pkg::engine_state_t state;       // engine state
  dma_pkg::engine_state_t next_state;
  logic ch;                            // channel being served
  logic [19:0] src_cur [2];            // effective source address
  logic [19:0] dst_cur [2];            // effective destination address
  logic [19:0] view_val [2];           // per-channel read-back
  logic [1:0] unit8_v;                 // per-channel 8-bit flag
  logic [1:0] pend_v;                  // per-channel pending request
  logic [1:0] en_v;                    // per-channel enable
  logic [1:0] uf_v;                    // per-channel underflow pulse
  wire any_pend = |pend_v;
  wire pick = !pend_v[0];              // channel_zero first
  wire start_eng = (state == dma_pkg::S_IDLE) && any_pend && bus_grant;
  wire [1:0] take_v = start_eng ? (pick ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] done_v = (state == dma_pkg::S_DONE) ? (ch ? 2'b10 : 2'b01) : 2'b00;

  // ----------------------------------------
  // channel register sets
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : chan
      logic en;              // enable bit
      logic rpt;             // repeat mode
      logic u8;              // 8-bit units
      logic sfwd;            // source forward
      logic dfwd;            // destination forward
      logic pend;            // request waiting for service
      logic [4:0] rsel;      // request selector
      logic [19:0] sp;       // source pointer
      logic [19:0] dp;       // destination pointer
      logic [19:0] fp;       // internal forward address pointer
      logic [15:0] rl;       // counter reload
      logic [15:0] cnt;      // transfer counter
      wire sel_cfg = cfg_write && (cfg_channel == 1'(c));
      wire w_ctrl = sel_cfg && (cfg_select == dma_pkg::REG_CTRL);
      wire new_en = cfg_data[dma_pkg::CTL_EN];
      wire new_sfwd = cfg_data[dma_pkg::CTL_SRC_FWD];
      wire start = w_ctrl && new_en && !en;
      wire stop = w_ctrl && !new_en;
      wire w_src = sel_cfg && (cfg_select == dma_pkg::REG_SRC) && (sfwd || !en);
      wire w_dst = sel_cfg && (cfg_select == dma_pkg::REG_DST) && (dfwd || !en);
      wire w_rl = sel_cfg && (cfg_select == dma_pkg::REG_RELOAD);
      wire periph_hit = (rsel < 5'(dma_pkg::PERIPH_N)) && periph_request[rsel[3:0]];
      // external edge only reaches its own channel
      wire hit = (rsel == dma_pkg::SEL_EXT) ? ext_fall[c] :
                 (rsel == dma_pkg::SEL_SW) ? soft_trigger[c] : periph_hit;
      wire done = done_v[c] && en;
      wire uf = done && (cnt == 16'h0000);              // decrement past zero
      wire [19:0] step = u8 ? dma_pkg::STEP_BYTE : dma_pkg::STEP_WORD;

      // configuration, start, per-unit update
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          en <= 1'b0;
          rpt <= 1'b0;
          u8 <= 1'b0;
          sfwd <= 1'b0;
          dfwd <= 1'b0;
          rsel <= 5'h00;
          sp <= 20'h00000;
          dp <= 20'h00000;
          fp <= 20'h00000;
          rl <= 16'h0000;
          cnt <= 16'h0000;
        end
        else
        begin
          if (w_ctrl)
          begin
            en <= new_en;                                 // zero shuts down
            rpt <= cfg_data[dma_pkg::CTL_REPEAT];
            u8 <= cfg_data[dma_pkg::CTL_UNIT8];
            sfwd <= new_sfwd;
            dfwd <= cfg_data[dma_pkg::CTL_DST_FWD] && !new_sfwd; // source wins
            rsel <= cfg_data[dma_pkg::CTL_SEL_LO +: 5];
          end
          if (w_src)
            sp <= cfg_data;
          if (w_dst)
            dp <= cfg_data;
          if (w_rl)
            rl <= cfg_data[15:0];
          if (start)
          begin
            fp <= new_sfwd ? sp : dp;
            cnt <= rl;
          end
          else if (uf)
          begin
            if (rpt)
            begin
              cnt <= rl;
              fp <= sfwd ? sp : dp;
            end
            else
              en <= 1'b0;
          end
          else if (done)
          begin
            cnt <= cnt - 16'h0001;
            fp <= fp + step;
          end
        end
      end

      // pending request, a new request beats the service clear
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          pend <= 1'b0;
        else if (stop)
          pend <= 1'b0;
        else if (hit && en)
          pend <= 1'b1;
        else if (take_v[c] || uf)
          pend <= 1'b0;                                   // only later requests resume
      end

      assign src_cur[c] = sfwd ? fp : sp;
      assign dst_cur[c] = dfwd ? fp : dp;
      assign unit8_v[c] = u8;
      assign pend_v[c] = pend;
      assign en_v[c] = en;
      assign uf_v[c] = uf;
      // live forward pointer while enabled
      assign view_val[c] =
        (view_select == dma_pkg::REG_SRC) ? ((sfwd && en) ? fp : sp) :
        (view_select == dma_pkg::REG_DST) ? ((dfwd && en) ? fp : dp) :
        (view_select == dma_pkg::REG_RELOAD) ? {4'h0, rl} :
        (view_select == dma_pkg::REG_COUNT) ? {4'h0, cnt} :
        (view_select == dma_pkg::REG_CTRL) ? {10'h000, rsel, dfwd, sfwd, u8, rpt, en} : 20'h00000;
    end
  endgenerate

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  logic part;            // second half of a split unit
  logic acc_two;         // current unit is split
  logic [1:0] timer;     // clocks left in current bus cycle
  logic [15:0] rbuf;     // unit assembled from reads
  logic [15:0] wbuf;     // unit being written
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out;
  wire iss_ch = (state == dma_pkg::S_IDLE) ? pick : ch;
  wire iss_wr = (state == dma_pkg::S_POP) || (state == dma_pkg::S_WR);
  wire iss_part = (state == dma_pkg::S_RD) || (state == dma_pkg::S_WR);
  wire [19:0] base = iss_wr ? dst_cur[iss_ch] : src_cur[iss_ch];
  wire iss_two = !unit8_v[iss_ch] && base[0];            // odd 16-bit
  wire iss_wide = !unit8_v[iss_ch] && !base[0];
  wire [19:0] iss_addr = base + {19'h00000, iss_part};
  // register area and software waits cost two clocks
  wire iss_slow = soft_wait_enable || (iss_addr <= dma_pkg::SFR_TOP);
  wire iss_guard = (iss_addr >= dma_pkg::GUARD_LO) && (iss_addr <= dma_pkg::GUARD_HI);
  wire [1:0] iss_wait = iss_slow ? (dma_pkg::WAIT_SLOW - 2'h1) : (dma_pkg::WAIT_FAST - 2'h1);
  wire [15:0] iss_data = (state == dma_pkg::S_POP) ? fifo_out : wbuf;
  wire [15:0] iss_wdata = iss_part ? {8'h00, iss_data[15:8]} : iss_data;
  wire last = (timer == 2'h0);
  wire more = acc_two && !part;
  wire in_acc = (state == dma_pkg::S_RD) || (state == dma_pkg::S_WR);
  wire do_issue = start_eng || (in_acc && last && more) ||
                  ((state == dma_pkg::S_POP) && fifo_out_valid);
  // a suppressed access reads as zero
  wire [15:0] rd_val = bus_strobe ? bus_rdata : 16'h0000;

  // ----------------------------------------
  // engine sequencing
  // ----------------------------------------
  // read, buffer, write, then release the bus
  always_comb
  begin
    next_state = state;
    unique case (state)
      dma_pkg::S_IDLE:
        if (start_eng)
          next_state = dma_pkg::S_RD;
      dma_pkg::S_RD:
        if (last && !more)
          next_state = dma_pkg::S_PUSH;
      dma_pkg::S_PUSH:
        if (fifo_in_ready)
          next_state = dma_pkg::S_POP;
      dma_pkg::S_POP:
        if (fifo_out_valid)
          next_state = dma_pkg::S_WR;
      dma_pkg::S_WR:
        if (last && !more)
          next_state = dma_pkg::S_DONE;
      dma_pkg::S_DONE:
        next_state = dma_pkg::S_IDLE;                    // bus given back per unit
    endcase
  end

  // state, channel and read assembly
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= dma_pkg::S_IDLE;
      ch <= 1'b0;
      rbuf <= 16'h0000;
      wbuf <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (start_eng)
        ch <= pick;
      if ((state == dma_pkg::S_POP) && fifo_out_valid)
        wbuf <= fifo_out;
      if ((state == dma_pkg::S_RD) && last)
      begin
        if (part)
          rbuf[15:8] <= rd_val[7:0];
        else if (bus_wide)
          rbuf <= rd_val;
        else
          rbuf <= {8'h00, rd_val[7:0]};
      end
    end
  end

  // bus cycle outputs, held for the cycle's clocks
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus_strobe <= 1'b0;
      bus_write <= 1'b0;
      bus_wide <= 1'b0;
      bus_addr <= 20'h00000;
      bus_wdata <= 16'h0000;
      timer <= 2'h0;
      part <= 1'b0;
      acc_two <= 1'b0;
    end
    else if (do_issue)
    begin
      bus_strobe <= !iss_guard;
      bus_write <= iss_wr;
      bus_wide <= iss_wide;
      bus_addr <= iss_addr;
      bus_wdata <= iss_wr ? iss_wdata : 16'h0000;
      timer <= iss_wait;
      part <= iss_part;
      acc_two <= iss_two;
    end
    else if (in_acc && last)
      bus_strobe <= 1'b0;
    else if (!last)
      timer <= timer - 2'h1;
  end

  // request, status and interrupt outputs
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus_request <= 1'b0;
      view_data <= 20'h00000;
      channel_enabled <= 2'h0;
      transfer_irq <= 2'h0;
    end
    else
    begin
      bus_request <= (next_state != dma_pkg::S_IDLE && next_state != dma_pkg::S_DONE) ||
                     (state == dma_pkg::S_IDLE && any_pend && !start_eng);
      view_data <= view_val[view_channel];
      channel_enabled <= en_v;
      transfer_irq <= uf_v;
    end
  end

  // ----------------------------------------
  // unit buffer between read and write
  // ----------------------------------------
  unit_fifo #(
    .WIDTH(dma_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) unit_buffer (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(state == dma_pkg::S_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(rbuf),
    .out_valid(fifo_out_valid),
    .out_ready(state == dma_pkg::S_POP),
    .out_data(fifo_out)
  );
endmodule

// ===== testbench/dma_bus_model.sv
/*
  arbiter and 4 kbyte memory on the system bus.
  assumes reads are taken in a strobe's last clock, bytes in the low lane.
*/
`timescale 1ns/100ps
module dma_bus_model (
  input wire logic clk,
  input wire logic grant_slow,
  input wire logic bus_request,
  input wire logic bus_strobe,
  input wire logic bus_write,
  input wire logic bus_wide,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic bus_grant,
  output logic [15:0] bus_rdata
);
  // ----------------------------------------
  // storage and arbitration
  // ----------------------------------------
  logic [7:0] mem [0:4095];
  logic [15:0] last_rdata = 16'h0000; // idle bus shows the inverse
  logic [1:0] hold = 2'h0; // cycles the request has waited
  wire logic [11:0] a = bus_addr[11:0];
  wire logic [11:0] a1 = a + 12'h001;

  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5a;

  // slow mode grants after three cycles
  assign bus_grant = bus_request && (!grant_slow || hold == 2'h3);
  // byte reads carry junk in the upper lane
  assign bus_rdata = (bus_strobe && !bus_write) ? (bus_wide ? {mem[a1], mem[a]} : {~mem[a], mem[a]}) : ~last_rdata;

  // memory write and wait counter
  always @(posedge clk)
  begin
    last_rdata <= bus_rdata;
    hold <= !bus_request ? 2'h0 : (hold == 2'h3 ? hold : hold + 2'h1);
    if (bus_strobe && bus_write && bus_wide)
      {mem[a1], mem[a]} <= bus_wdata;
    else if (bus_strobe && bus_write)
      mem[a] <= bus_wdata[7:0];
  end
endmodule

// ===== testbench/dma_sva.sv
/*
  port-level checker for the dma controller.
  assumes one clock and a synchronous reset.
*/
`timescale 1ns/100ps
module dma_sva #(
  parameter int FIFO_DEPTH = dma_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic soft_wait_enable,
  input wire logic cfg_write,
  input wire logic cfg_channel,
  input wire logic [2:0] cfg_select,
  input wire logic [dma_pkg::ADDR_W-1:0] cfg_data,
  input wire logic bus_request,
  input wire logic bus_strobe,
  input wire logic bus_write,
  input wire logic bus_wide,
  input wire logic [dma_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [1:0] channel_enabled,
  input wire logic [1:0] transfer_irq
);
  // ----------------------------------------
  // helper decode
  // ----------------------------------------
  logic [1:0] repeat_mode; // mode bit last written per channel
  wire logic ctrl_wr = cfg_write && cfg_select == dma_pkg::REG_CTRL;
  wire logic guarded = bus_addr >= dma_pkg::GUARD_LO && bus_addr <= dma_pkg::GUARD_HI;
  // waited bus cycle
  wire logic slow_cyc = soft_wait_enable || bus_addr <= dma_pkg::SFR_TOP;

  // shadow of the mode bit
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      repeat_mode <= 2'h0;
    else if (ctrl_wr)
      repeat_mode[cfg_channel] <= cfg_data[dma_pkg::CTL_REPEAT];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_strobe_owned: assert property (bus_strobe |-> bus_request)
    else $error("strobe without bus request");
  a_bus_released: assert property (bus_request |-> ##[1:60] !bus_request)
    else $error("bus held too long");
  a_guard_quiet: assert property (bus_strobe |-> !guarded)
    else $error("access to controller registers");
  a_wide_even: assert property (bus_strobe && bus_wide |-> !bus_addr[0])
    else $error("wide access at odd address");
  a_slow_hold: assert property ($rose(bus_strobe) && slow_cyc |=> bus_strobe && $stable(bus_addr))
    else $error("waited cycle too short");
  a_fast_single: assert property ($rose(bus_strobe) && !slow_cyc |=> !bus_strobe || bus_addr != $past(bus_addr))
    else $error("fast cycle too long");
  a_write_last: assert property ($fell(bus_request) |-> $past(bus_strobe && bus_write))
    else $error("unit did not end with a write");
  a_irq_pulse: assert property (transfer_irq != 2'h0 |=> transfer_irq == 2'h0)
    else $error("irq longer than one cycle");
  a_irq_after_unit: assert property (transfer_irq != 2'h0 |-> $past(bus_request) == 1'b0)
    else $error("irq not after a unit");
  a_single_stops: assert property (transfer_irq[0] && !repeat_mode[0] |-> ##[0:2] !channel_enabled[0])
    else $error("single mode channel still enabled");
  a_repeat_stays: assert property (transfer_irq[1] && repeat_mode[1] |-> channel_enabled[1][*3])
    else $error("repeat mode channel dropped");
  a_stop_write: assert property (ctrl_wr && cfg_channel && !cfg_data[0] |-> ##2 !channel_enabled[1])
    else $error("channel not stopped by enable write");

  c_irq: cover property (transfer_irq[0]);
  c_wide: cover property (bus_strobe && bus_wide);
  c_waited: cover property ($rose(bus_strobe) && soft_wait_enable);
endmodule

bind two_channel_dma_controller dma_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.clk(clk), .reset_n(reset_n),
  .soft_wait_enable(soft_wait_enable), .cfg_write(cfg_write), .cfg_channel(cfg_channel),
  .cfg_select(cfg_select), .cfg_data(cfg_data), .bus_request(bus_request), .bus_strobe(bus_strobe),
  .bus_write(bus_write), .bus_wide(bus_wide), .bus_addr(bus_addr), .channel_enabled(channel_enabled),
  .transfer_irq(transfer_irq));

// ===== testbench/two_channel_dma_controller_test.sv
/*
  self-checking bench for the dma controller.
  assumes dma_bus_model as bus partner and the bound checker.
*/
`timescale 1ns/100ps
module two_channel_dma_controller_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic external_irq_line_zero = 1'b1, external_irq_line_one = 1'b1;
  logic [14:0] periph_request = 15'h0000;
  logic [1:0] soft_trigger = 2'h0;
  logic soft_wait_enable = 1'b0, cfg_write = 1'b0, cfg_channel = 1'b0, view_channel = 1'b0, grant_slow = 1'b0;
  logic [2:0] cfg_select = 3'h0, view_select = 3'h0;
  logic [19:0] cfg_data = 20'h00000, view_data, bus_addr, first_addr, prev_addr;
  logic [15:0] bus_rdata, bus_wdata;
  logic bus_grant, bus_request, bus_strobe, bus_write, bus_wide, prev_strobe;
  logic [1:0] channel_enabled, transfer_irq;
  int n_errors = 0, check_count = 0, n_cyc = 0, n_irq0 = 0, n_irq1 = 0;

  always #5 clk = ~clk;

  two_channel_dma_controller dut_u (.clk(clk), .reset_n(reset_n), .external_irq_line_zero(external_irq_line_zero),
    .external_irq_line_one(external_irq_line_one), .periph_request(periph_request), .soft_trigger(soft_trigger),
    .soft_wait_enable(soft_wait_enable), .cfg_write(cfg_write), .cfg_channel(cfg_channel), .cfg_select(cfg_select),
    .cfg_data(cfg_data), .view_channel(view_channel), .view_select(view_select), .view_data(view_data),
    .bus_grant(bus_grant), .bus_rdata(bus_rdata), .bus_request(bus_request), .bus_strobe(bus_strobe),
    .bus_write(bus_write), .bus_wide(bus_wide), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .channel_enabled(channel_enabled), .transfer_irq(transfer_irq));

  dma_bus_model mem_u (.clk(clk), .grant_slow(grant_slow), .bus_request(bus_request), .bus_strobe(bus_strobe),
    .bus_write(bus_write), .bus_wide(bus_wide), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_grant(bus_grant), .bus_rdata(bus_rdata));

  // bus cycle and interrupt counters
  always @(posedge clk)
  begin
    if (bus_strobe && (!prev_strobe || bus_addr !== prev_addr))
    begin
      if (n_cyc == 0)
        first_addr = bus_addr;
      n_cyc++;
    end
    n_irq0 += transfer_irq[0];
    n_irq1 += transfer_irq[1];
    prev_strobe = bus_strobe;
    prev_addr = bus_addr;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [19:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cfg(input logic ch, input logic [2:0] sel, input logic [19:0] d);
    @(posedge clk);
    cfg_write <= 1'b1;
    cfg_channel <= ch;
    cfg_select <= sel;
    cfg_data <= d;
    @(posedge clk);
    cfg_write <= 1'b0;
  endtask

  // view data settles one edge after the selection
  task automatic view(input logic ch, input logic [2:0] sel, input logic [19:0] exp);
    @(posedge clk);
    view_channel <= ch;
    view_select <= sel;
    repeat (2) @(posedge clk);
    #1;
    check(view_data, exp);
  endtask

  // pointers and reload precede the starting enable write
  task automatic setup(input logic ch, input logic [19:0] src, dst, rl, ctl);
    cfg(ch, dma_pkg::REG_SRC, src);
    cfg(ch, dma_pkg::REG_DST, dst);
    cfg(ch, dma_pkg::REG_RELOAD, rl);
    cfg(ch, dma_pkg::REG_CTRL, ctl);
    n_cyc = 0;
  endtask

  // control word; destination forward when source fixed
  function automatic logic [19:0] ctl(input logic rep, u8, sfwd, input logic [4:0] sel);
    return {10'h000, sel, ~sfwd, sfwd, u8, rep, 1'b1};
  endfunction

  task automatic pulse(input logic [1:0] sw, input logic [14:0] pr);
    @(posedge clk);
    soft_trigger <= sw;
    periph_request <= pr;
    @(posedge clk);
    soft_trigger <= 2'h0;
    periph_request <= 15'h0000;
  endtask

  // one unit takes and frees the bus, then the irq slot
  task automatic wait_unit;
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 200; i++)
    begin
      @(posedge clk);
      #1;
      if (bus_request)
        seen = 1'b1;
      else if (seen)
      begin
        repeat (2) @(posedge clk);
        #1;
        return;
      end
    end
    n_errors++;
    tally_and_finish();
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check({bus_request, bus_strobe, channel_enabled, transfer_irq}, 20'h00000);
    // single 8-bit on a peripheral line; early requests ignored
    pulse(2'h3, 15'h7fff);
    setup(1'b0, 20'h00500, 20'h00800, 20'h00002, ctl(1'b0, 1'b1, 1'b1, 5'h03));
    repeat (10) @(posedge clk);
    check(n_cyc, 20'h00000);
    pulse(2'h0, 15'h0008);
    wait_unit();
    view(1'b0, dma_pkg::REG_SRC, 20'h00501);
    view(1'b0, dma_pkg::REG_COUNT, 20'h00001);
    pulse(2'h0, 15'h0008);
    wait_unit();
    pulse(2'h0, 15'h0008);
    wait_unit();
    check(n_cyc, 20'h00006);
    check(n_irq0, 20'h00001);
    check(channel_enabled, 2'h0);
    check(mem_u.mem[12'h800], 8'h58);
    // repeat 16-bit from odd addresses, slow grant
    @(posedge clk);
    grant_slow <= 1'b1;
    setup(1'b1, 20'h00601, 20'h00901, 20'h00000, ctl(1'b1, 1'b0, 1'b1, dma_pkg::SEL_SW));
    pulse(2'h2, 15'h0000);
    wait_unit();
    check(n_cyc, 20'h00004);
    check({mem_u.mem[12'h902], mem_u.mem[12'h901]}, 16'h585b);
    check(n_irq1, 20'h00001);
    check(channel_enabled, 2'h2);
    view(1'b1, dma_pkg::REG_SRC, 20'h00601);
    view(1'b1, dma_pkg::REG_COUNT, 20'h00000);
    cfg(1'b1, dma_pkg::REG_DST, 20'h00777);
    view(1'b1, dma_pkg::REG_DST, 20'h00901);
    cfg(1'b1, dma_pkg::REG_SRC, 20'h00611);
    cfg(1'b1, dma_pkg::REG_CTRL, 20'h00000);
    repeat (2) @(posedge clk);
    #1;
    check(channel_enabled, 2'h0);
    n_cyc = 0;
    pulse(2'h2, 15'h0000);
    repeat (10) @(posedge clk);
    check(n_cyc, 20'h00000);
    view(1'b1, dma_pkg::REG_SRC, 20'h00611);
    @(posedge clk);
    grant_slow <= 1'b0;
    // simultaneous requests with software waits
    soft_wait_enable <= 1'b1;
    setup(1'b1, 20'h00620, 20'h00920, 20'h00000, ctl(1'b1, 1'b0, 1'b1, dma_pkg::SEL_SW));
    setup(1'b0, 20'h00510, 20'h00810, 20'h00000, ctl(1'b0, 1'b1, 1'b1, dma_pkg::SEL_SW));
    pulse(2'h3, 15'h0000);
    wait_unit();
    wait_unit();
    check(first_addr, 20'h00510);
    check(n_cyc, 20'h00004);
    check(mem_u.mem[12'h810], 8'h4a);
    check({mem_u.mem[12'h921], mem_u.mem[12'h920]}, 16'h7b7a);
    cfg(1'b1, dma_pkg::REG_CTRL, 20'h00000);
    soft_wait_enable <= 1'b0;
    // external edge, guarded fixed source
    setup(1'b0, 20'h00030, 20'h00840, 20'h00000, ctl(1'b0, 1'b1, 1'b0, dma_pkg::SEL_EXT));
    external_irq_line_one <= 1'b0;
    repeat (10) @(posedge clk);
    check(n_cyc, 20'h00000);
    external_irq_line_zero <= 1'b0;
    wait_unit();
    check(n_cyc, 20'h00001);
    check(mem_u.mem[12'h840], 8'h00);
    check(n_irq0, 20'h00003);
    tally_and_finish();
  end
endmodule
